// [src/lsr_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - writable 16-bit upper threshold at command 01h
// - writable 16-bit lower threshold at command 02h
// - command 03h bits 2:1 select mode 1-4
// - command 03h bit 0 enables power saving
// - ambient result readable at command 04h
// - white result readable at command 05h
// - bits 15:8 high byte, 7:0 low byte
// - answer only bus address 10h, 20h/21h
// - results hold while shut down, stay readable
// - config bit0 shutdown, bit1 threshold interrupt enable
// - status bit15 below low, bit14 above high
module lsr_regs
    import lsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire lsr_sample_t sample_in,
    output logic [15:0] config_out,
    output logic shutdown_control_out,
    output logic threshold_irq_enable_out,
    output logic [15:0] upper_threshold_out,
    output logic [15:0] lower_threshold_out,
    output lsr_psave_t power_save_out,
    output logic [15:0] ambient_result_out,
    output logic [15:0] white_result_out,
    output logic below_low_flag_out,
    output logic above_high_flag_out
);
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    lsr_state_t state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic rw, master_ack, sda_drive;
    logic [7:0] cmd, wlsb;
    logic [15:0] rd_mux, rd_hold;
    logic wr_en, rd_load, rd_first, status_clear;
    logic [15:0] wr_word;

    // two-stage synchronisers, third stage only for edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
        end
    end

    assign scl_rise = scl_sync[1] && !scl_sync[2];
    assign scl_fall = !scl_sync[1] && scl_sync[2];
    assign bus_start = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
    assign bus_stop = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];

    assign wr_word = {shreg, wlsb};
    assign wr_en = scl_fall && state == LSR_WRITE && bitcnt == LSR_BITS_PER_BYTE && byte_idx == LSR_IDX_MSB;
    assign rd_load = scl_fall && ((state == LSR_ACK && rw) || (state == LSR_RACK && master_ack));
    assign rd_first = state == LSR_ACK;
    assign status_clear = rd_load && rd_first && cmd == LSR_CMD_STATUS;

    always_comb begin
        unique case (cmd)
            LSR_CMD_CONFIG: rd_mux = config_out;
            LSR_CMD_UPPER: rd_mux = upper_threshold_out;
            LSR_CMD_LOWER: rd_mux = lower_threshold_out;
            LSR_CMD_PSAVE: rd_mux = {13'h0, power_save_out};
            LSR_CMD_AMBIENT: rd_mux = ambient_result_out;
            LSR_CMD_WHITE: rd_mux = white_result_out;
            LSR_CMD_STATUS: rd_mux = {below_low_flag_out, above_high_flag_out, 14'h0};
            default: rd_mux = 16'h0000;
        endcase
    end

    // bus protocol engine
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= LSR_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            byte_idx <= LSR_IDX_CMD;
            rw <= 1'b0;
            master_ack <= 1'b0;
            sda_drive <= 1'b0;
            cmd <= 8'h00;
            wlsb <= 8'h00;
            rd_hold <= 16'h0000;
        end else if (bus_start) begin
            state <= LSR_ADDR;
            bitcnt <= 4'h0;
            byte_idx <= LSR_IDX_CMD;
            sda_drive <= 1'b0;
        end else if (bus_stop) begin
            state <= LSR_IDLE;
            sda_drive <= 1'b0;
        end else begin
            unique case (state)
                LSR_IDLE: sda_drive <= 1'b0;
                LSR_ADDR, LSR_WRITE: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_sync[1]};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == LSR_BITS_PER_BYTE) begin
                        if (state == LSR_ADDR) begin
                            if (shreg[7:1] == LSR_BUS_ADDR) begin
                                rw <= shreg[0];
                                sda_drive <= 1'b1;
                                state <= LSR_ACK;
                            end else begin
                                state <= LSR_IDLE;
                            end
                        end else begin
                            sda_drive <= 1'b1;
                            state <= LSR_ACK;
                            if (byte_idx == LSR_IDX_CMD) begin
                                cmd <= shreg;
                            end else if (byte_idx == LSR_IDX_LSB) begin
                                wlsb <= shreg;
                            end
                            byte_idx <= (byte_idx == LSR_IDX_MSB) ? LSR_IDX_LSB : byte_idx + 2'h1;
                        end
                    end
                end
                LSR_ACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        if (rw) begin
                            rd_hold <= rd_mux;
                            shreg <= rd_mux[7:0];
                            sda_drive <= !rd_mux[7];
                            state <= LSR_READ;
                        end else begin
                            sda_drive <= 1'b0;
                            state <= LSR_WRITE;
                        end
                    end
                end
                LSR_READ: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt == LSR_BITS_PER_BYTE) begin
                            sda_drive <= 1'b0;
                            state <= LSR_RACK;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_drive <= !shreg[6];
                        end
                    end
                end
                LSR_RACK: begin
                    if (scl_rise) begin
                        master_ack <= !sda_sync[1];
                    end else if (scl_fall) begin
                        bitcnt <= 4'h0;
                        if (master_ack) begin
                            // after the low byte the high byte; then the same held bytes again in turn
                            shreg <= rd_hold[15:8];
                            sda_drive <= !rd_hold[15];
                            rd_hold <= {rd_hold[7:0], rd_hold[15:8]};
                            state <= LSR_READ;
                        end else begin
                            state <= LSR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n_out = !sda_drive;

    // host-written registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_out <= LSR_CONFIG_RESET;
            upper_threshold_out <= LSR_THRESH_RESET;
            lower_threshold_out <= LSR_THRESH_RESET;
            power_save_out <= LSR_PSAVE_RESET;
        end else if (wr_en) begin
            unique case (cmd)
                LSR_CMD_CONFIG: config_out <= wr_word;
                LSR_CMD_UPPER: upper_threshold_out <= wr_word;
                LSR_CMD_LOWER: lower_threshold_out <= wr_word;
                LSR_CMD_PSAVE: begin
                    // bits 15:3 carry no function and are dropped
                    power_save_out.mode <= wr_word[LSR_PS_MODE_LO +: 2];
                    power_save_out.enable <= wr_word[LSR_PS_EN_BIT];
                end
                default: ;
            endcase
        end
    end

    assign shutdown_control_out = config_out[LSR_CFG_SHUTDOWN_BIT];
    assign threshold_irq_enable_out = config_out[LSR_CFG_IRQ_EN_BIT];

    // results only refresh while powered on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ambient_result_out <= LSR_RESULT_RESET;
            white_result_out <= LSR_RESULT_RESET;
        end else if (sample_in.valid && !shutdown_control_out) begin
            ambient_result_out <= sample_in.ambient;
            white_result_out <= sample_in.white;
        end
    end

    // threshold flags, set beats the read-clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            below_low_flag_out <= 1'b0;
            above_high_flag_out <= 1'b0;
        end else begin
            if (sample_in.valid && !shutdown_control_out && threshold_irq_enable_out
                    && sample_in.ambient < lower_threshold_out) begin
                below_low_flag_out <= 1'b1;
            end else if (status_clear) begin
                below_low_flag_out <= 1'b0;
            end
            if (sample_in.valid && !shutdown_control_out && threshold_irq_enable_out
                    && sample_in.ambient > upper_threshold_out) begin
                above_high_flag_out <= 1'b1;
            end else if (status_clear) begin
                above_high_flag_out <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_upper_write;
        wr_en && cmd == LSR_CMD_UPPER |=> upper_threshold_out == $past(wr_word);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("upper threshold not written");
    property p_lower_write;
        wr_en && cmd == LSR_CMD_LOWER |=> lower_threshold_out == $past(wr_word);
    endproperty
    a_lower_write: assert property (p_lower_write) else $error("lower threshold not written");
    property p_psave_mode;
        wr_en && cmd == LSR_CMD_PSAVE |=> power_save_out.mode == $past(wr_word[2:1]);
    endproperty
    a_psave_mode: assert property (p_psave_mode) else $error("power save mode wrong");
    property p_psave_enable;
        wr_en && cmd == LSR_CMD_PSAVE |=> power_save_out.enable == $past(wr_word[0]);
    endproperty
    a_psave_enable: assert property (p_psave_enable) else $error("power save enable wrong");
    property p_ambient_read;
        rd_load && rd_first && cmd == LSR_CMD_AMBIENT |=> rd_hold == $past(ambient_result_out);
    endproperty
    a_ambient_read: assert property (p_ambient_read) else $error("ambient read wrong");
    property p_white_read;
        rd_load && rd_first && cmd == LSR_CMD_WHITE |=> rd_hold == $past(white_result_out);
    endproperty
    a_white_read: assert property (p_white_read) else $error("white read wrong");
    property p_low_byte_first;
        rd_load && rd_first |=> shreg == $past(rd_mux[7:0]) ##0 sda_drive == !$past(rd_mux[7]);
    endproperty
    a_low_byte_first: assert property (p_low_byte_first) else $error("low byte not sent first");
    property p_foreign_addr;
        scl_fall && state == LSR_ADDR && bitcnt == LSR_BITS_PER_BYTE && shreg[7:1] != LSR_BUS_ADDR
            && !bus_start && !bus_stop |=> state == LSR_IDLE && !sda_drive;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address answered");
    property p_hold_in_shutdown;
        shutdown_control_out |=> $stable(ambient_result_out) && $stable(white_result_out);
    endproperty
    a_hold_in_shutdown: assert property (p_hold_in_shutdown) else $error("result changed in shutdown");
    property p_flag_needs_enable;
        $rose(above_high_flag_out) || $rose(below_low_flag_out) |-> $past(threshold_irq_enable_out);
    endproperty
    a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("flag without enable");
    property p_above_high;
        sample_in.valid && !shutdown_control_out && threshold_irq_enable_out
            && sample_in.ambient > upper_threshold_out |=> above_high_flag_out;
    endproperty
    a_above_high: assert property (p_above_high) else $error("above-high flag missed");
    c_write: cover property (wr_en && cmd == LSR_CMD_UPPER);
    c_read_ambient: cover property (rd_load && rd_first && cmd == LSR_CMD_AMBIENT);
    c_status_clear: cover property (status_clear && above_high_flag_out);
    c_high_byte: cover property (rd_load && !rd_first);
endmodule : lsr_regs
`default_nettype wire

// [src/lsr_pkg.sv]
`default_nettype none
package lsr_pkg;
    localparam logic [6:0] LSR_BUS_ADDR = 7'h10;
    localparam logic [7:0] LSR_CMD_CONFIG = 8'h00;
    localparam logic [7:0] LSR_CMD_UPPER = 8'h01;
    localparam logic [7:0] LSR_CMD_LOWER = 8'h02;
    localparam logic [7:0] LSR_CMD_PSAVE = 8'h03;
    localparam logic [7:0] LSR_CMD_AMBIENT = 8'h04;
    localparam logic [7:0] LSR_CMD_WHITE = 8'h05;
    localparam logic [7:0] LSR_CMD_STATUS = 8'h06;
    localparam int LSR_CFG_SHUTDOWN_BIT = 0;
    localparam int LSR_CFG_IRQ_EN_BIT = 1;
    localparam int LSR_PS_EN_BIT = 0;
    localparam int LSR_PS_MODE_LO = 1;
    localparam int LSR_ST_LOW_BIT = 15;
    localparam int LSR_ST_HIGH_BIT = 14;
    localparam logic [15:0] LSR_CONFIG_RESET = 16'h0001;
    localparam logic [15:0] LSR_THRESH_RESET = 16'h0000;
    localparam logic [15:0] LSR_RESULT_RESET = 16'h0000;
    localparam logic [3:0] LSR_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] LSR_IDX_CMD = 2'h0;
    localparam logic [1:0] LSR_IDX_LSB = 2'h1;
    localparam logic [1:0] LSR_IDX_MSB = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic enable;
    } lsr_psave_t;

    typedef struct packed {
        logic valid;
        logic [15:0] ambient;
        logic [15:0] white;
    } lsr_sample_t;

    localparam lsr_psave_t LSR_PSAVE_RESET = '{mode: 2'h0, enable: 1'b0};

    typedef enum logic [5:0] {
        LSR_IDLE = 6'h01,
        LSR_ADDR = 6'h02,
        LSR_ACK = 6'h04,
        LSR_WRITE = 6'h08,
        LSR_READ = 6'h10,
        LSR_RACK = 6'h20
    } lsr_state_t;
endpackage : lsr_pkg
`default_nettype wire

// [test/lsr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module lsr_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // quarter of a bus bit, in system clocks; well above the sync delay
    localparam int Q = 6;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic wq();
        repeat (Q) @(posedge clk_in);
        #1;
    endtask : wq

    task automatic bit_io(input logic b, output logic r);
        sda_low_out = ~b;
        wq();
        scl_out = 1'b1;
        wq();
        r = sda_in;
        wq();
        scl_out = 1'b0;
        wq();
    endtask : bit_io

    // also serves as repeated start: line released first, then pulled low with clock high
    task automatic start();
        sda_low_out = 1'b0;
        wq();
        scl_out = 1'b1;
        wq();
        sda_low_out = 1'b1;
        wq();
        scl_out = 1'b0;
        wq();
    endtask : start

    task automatic stop();
        sda_low_out = 1'b1;
        wq();
        scl_out = 1'b1;
        wq();
        sda_low_out = 1'b0;
        wq();
    endtask : stop

    // eight bits msb first, then the ninth bit driven as last and read back
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, nak);
    endtask : xfer

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] v,
                             input logic whole, output logic ok);
        logic [7:0] q;
        logic n0, n1, n2, n3;
        start();
        xfer({addr, 1'b0}, 1'b1, q, n0);
        xfer(cmd, 1'b1, q, n1);
        xfer(v[7:0], 1'b1, q, n2);
        n3 = 1'b0;
        if (whole) begin
            xfer(v[15:8], 1'b1, q, n3);
        end
        stop();
        ok = !(n0 | n1 | n2 | n3);
    endtask : write_reg

    task automatic read_reg(input logic [7:0] cmd, output logic [15:0] v, output logic ok);
        logic [7:0] q;
        logic n0, n1, n2, n3;
        start();
        xfer(8'h20, 1'b1, q, n0);
        xfer(cmd, 1'b1, q, n1);
        start();
        xfer(8'h21, 1'b1, q, n2);
        xfer(8'hff, 1'b0, v[7:0], n3);
        xfer(8'hff, 1'b1, v[15:8], n3);
        stop();
        ok = !(n0 | n1 | n2);
    endtask : read_reg
endmodule : lsr_host
`default_nettype wire

// [test/light_sensor_threshold_psm_output_regs_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module light_sensor_threshold_psm_output_regs_test
    import lsr_pkg::*;
;
    logic clk, rst_n, scl, host_low, sda, sda_drv, sda_oe_n, shut, irq_en, low_flag, high_flag, ok;
    logic [15:0] cfg, upper, lower, amb, wht, rd;
    lsr_sample_t sample;
    lsr_psave_t psave;
    int failures = 0;
    int checks_done = 0;
    typedef struct {logic [7:0] cmd; logic [15:0] val;} lsr_row_t;
    // reserved power-save bits always written as zero
    lsr_row_t rows[7] = '{
        '{8'h01, 16'hffff},
        '{8'h01, 16'h9000},
        '{8'h02, 16'h0100},
        '{8'h03, 16'h0001},
        '{8'h03, 16'h0002},
        '{8'h03, 16'h0005},
        '{8'h03, 16'h0006}};

    assign sda = (sda_oe_n ? 1'b1 : sda_drv) & ~host_low;

    lsr_regs dut (.clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
        .sda_oe_n_out(sda_oe_n), .sample_in(sample), .config_out(cfg), .shutdown_control_out(shut),
        .threshold_irq_enable_out(irq_en), .upper_threshold_out(upper), .lower_threshold_out(lower),
        .power_save_out(psave), .ambient_result_out(amb), .white_result_out(wht),
        .below_low_flag_out(low_flag), .above_high_flag_out(high_flag));
    lsr_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));

    function automatic logic [15:0] port_of(input logic [7:0] c);
        if (c == LSR_CMD_UPPER) return upper;
        if (c == LSR_CMD_LOWER) return lower;
        return {13'h0, psave};
    endfunction : port_of

    task automatic print_verdict();
        $display("failures=%0d checks=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic pulse(input logic [15:0] a, input logic [15:0] w);
        @(posedge clk);
        #1 sample = '{valid: 1'b1, ambient: a, white: w};
        @(posedge clk);
        #1 sample.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse

    task automatic set_cfg(input logic [15:0] v);
        host.write_reg(LSR_BUS_ADDR, LSR_CMD_CONFIG, v, 1'b1, ok);
    endtask : set_cfg

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        sample = '0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHECK({cfg, shut}, 17'h00003)
        `CHECK({upper, lower, amb, wht, sda_oe_n}, 65'h1)
        foreach (rows[i]) begin
            host.write_reg(LSR_BUS_ADDR, rows[i].cmd, rows[i].val, 1'b1, ok);
            `CHECK(ok, 1'b1)
            `CHECK(port_of(rows[i].cmd), rows[i].val)
            host.read_reg(rows[i].cmd, rd, ok);
            `CHECK({ok, rd}, {1'b1, rows[i].val})
        end
        // samples are ignored while shut down
        pulse(16'h0050, 16'h0abc);
        `CHECK({amb, wht}, 32'h0)
        set_cfg(16'h0002);
        `CHECK({shut, irq_en}, 2'b01)
        pulse(16'h0050, 16'h0abc);
        `CHECK({amb, wht}, 32'h00500abc)
        `CHECK({low_flag, high_flag}, 2'b10)
        host.read_reg(LSR_CMD_AMBIENT, rd, ok);
        `CHECK({ok, rd}, 17'h10050)
        host.read_reg(LSR_CMD_WHITE, rd, ok);
        `CHECK({ok, rd}, 17'h10abc)
        host.read_reg(LSR_CMD_CONFIG, rd, ok);
        `CHECK({ok, rd}, 17'h10002)
        set_cfg(16'h0003);
        pulse(16'h9001, 16'h1111);
        host.read_reg(LSR_CMD_AMBIENT, rd, ok);
        `CHECK({rd, amb, wht}, 48'h005000500abc)
        set_cfg(16'h0002);
        pulse(16'h9001, 16'h1111);
        `CHECK({amb, low_flag, high_flag}, 18'h24007)
        // foreign address must be ignored
        host.write_reg(7'h11, LSR_CMD_UPPER, 16'h0000, 1'b1, ok);
        `CHECK({ok, upper}, 17'h09000)
        // lone low byte must not write
        host.write_reg(LSR_BUS_ADDR, LSR_CMD_LOWER, 16'h00ee, 1'b0, ok);
        `CHECK(lower, 16'h0100)
        // reading the status word hands over both flags and clears them
        host.read_reg(LSR_CMD_STATUS, rd, ok);
        `CHECK({ok, rd}, 17'h1c000)
        `CHECK({low_flag, high_flag}, 2'b00)
        host.read_reg(LSR_CMD_STATUS, rd, ok);
        `CHECK({ok, rd}, 17'h10000)
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        `CHECK({cfg, upper, amb}, 48'h000100000000)
        `CHECK({lower, wht, psave, low_flag, high_flag, sda_oe_n}, 38'h1)
        print_verdict();
    end
endmodule : light_sensor_threshold_psm_output_regs_test
`default_nettype wire
